/* pkg/spt_pkg.sv */
package spt_pkg;
   // Serial word
   localparam int WORD_W = 32;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] CNT_LAST = 6'h1f;
   // Selector and variable identifiers
   localparam int SEL_W = 16;
   localparam logic [SEL_W-1:0] SEL_RST = 16'hfa4e;
   localparam logic [SEL_W-1:0] VAR_POS_ID = 16'hfa4e;
   localparam logic [SEL_W-1:0] SEL_PARAM_NUM = 16'h0766;
   // Idle gap in link clocks after which a new frame starts
   localparam logic [3:0] GAP_CNT = 4'h2;
   localparam logic [3:0] GAP_RST = 4'h0;
   // Buffer
   localparam int BUF_DEPTH = 2;
   typedef struct packed {
      logic [SEL_W-1:0] sel;
      logic [WORD_W-1:0] value;
   } spt_word_s;
endpackage

/* rtl/spt_transmitter.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Transmit only; no data input from the far end exists.
// - Message is header, payload, optional CRC; here payload only is sent.
// - Most significant byte and bit go out first.
// - One data bit leaves per received clock pulse.
// - Data output changes on each rising edge of the link clock.
// - Value is sent as plain binary, no Gray coding.
// - Each transfer carries exactly 32 bits.
// - A 16-bit selector chooses which internal variable is sent.
// - Selector 64078 sends position minus home offset, signed 32-bit.
// - Every transfer stands alone; no state carries between transfers. Here latest_q keeps the last word, which is resent until a new one arrives.
module spt_transmitter
   import spt_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [SEL_W-1:0] var_sel,
   input wire logic signed [WORD_W-1:0] position,
   input wire logic signed [WORD_W-1:0] home_offset,
   input wire logic [WORD_W-1:0] alt_value,
   input wire logic src_valid,
   output logic src_ready,
   input wire logic link_clk,
   input wire logic link_nrst,
   input wire logic frame_start,
   output logic data_out,
   output logic busy
);

   // Handshake state seen by both domains, declared before either uses it
   logic req_q;
   logic req_d;
   logic ack_lk_q;
   logic ack_lk_d;
   spt_word_s hold_q;
   spt_word_s hold_d;

   // Sample source: chooses the variable on the system clock
   logic signed [WORD_W-1:0] pos_rel;
   logic [WORD_W-1:0] sel_value;
   logic sel_is_pos;
   spt_word_s in_word;
   assign sel_is_pos = (var_sel == VAR_POS_ID);
   assign pos_rel = position - home_offset;
   // Sent as plain binary; no Gray or other coding on the way out
   assign sel_value = sel_is_pos ? pos_rel : alt_value;
   assign in_word = '{sel: var_sel, value: sel_value};

   // Two-entry buffer: a stalled link holds the source off via src_ready; latest_q keeps only the newest word
   logic buf_valid;
   logic buf_take;
   spt_word_s buf_word;
   spt_buf2 u_spt_buf2 (
      .clk(clk),
      .nrst(nrst),
      .in_valid(src_valid),
      .in_ready(src_ready),
      .in_word(in_word),
      .out_valid(buf_valid),
      .out_ready(buf_take),
      .out_word(buf_word)
   );

   // Return toggle from the link side
   logic ack_sync;
   spt_sync3 u_spt_sync3_ack (
      .clk(clk),
      .nrst(nrst),
      .d(ack_lk_q),
      .sync_q(ack_sync)
   );

   // The held word changes only while no toggle is in flight, so the
   // link side reads it without synchronising all of its bits
   logic hold_free;
   logic take;
   assign hold_free = (req_q == ack_sync);
   assign buf_take = hold_free;
   assign take = buf_valid && hold_free;
   assign req_d = take ? ~req_q : req_q;
   assign hold_d = take ? buf_word : hold_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         req_q <= 1'b0;
      end else begin
         req_q <= req_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hold_q <= '0;
      end else begin
         hold_q <= hold_d;
      end
   end

   // Link domain: runs only on the controller's clock, which may stop
   // between frames; a waiting word is picked up in a later frame
   logic req_sync;
   logic new_word;
   logic [WORD_W-1:0] latest_q;
   logic [WORD_W-1:0] latest_d;
   spt_sync3 u_spt_sync3_req (
      .clk(link_clk),
      .nrst(link_nrst),
      .d(req_q),
      .sync_q(req_sync)
   );
   assign new_word = (req_sync != ack_lk_q);
   assign ack_lk_d = new_word ? req_sync : ack_lk_q;
   assign latest_d = new_word ? hold_q.value : latest_q;

   always_ff @(posedge link_clk or negedge link_nrst) begin
      if (!link_nrst) begin
         ack_lk_q <= 1'b0;
      end else begin
         ack_lk_q <= ack_lk_d;
      end
   end

   always_ff @(posedge link_clk or negedge link_nrst) begin
      if (!link_nrst) begin
         latest_q <= '0;
      end else begin
         latest_q <= latest_d;
      end
   end

   // Shifter: the link has a data output only; nothing from the far
   // end is ever read
   logic [WORD_W-1:0] shift_q;
   logic [WORD_W-1:0] shift_d;
   logic [CNT_W-1:0] bit_q;
   logic [CNT_W-1:0] bit_d;
   logic active_q;
   logic active_d;
   logic data_d;
   logic busy_d;
   logic last_bit;
   assign last_bit = (bit_q == CNT_LAST - 6'h01);

   // Payload only: the optional header and CRC are left out, so the
   // controller sees a bare word, MSB first
   always_comb begin
      shift_d = shift_q;
      bit_d = bit_q;
      active_d = active_q;
      data_d = 1'b0;
      busy_d = busy;
      if (frame_start) begin
         // A restart mid-frame drops the old word; nothing carries over
         shift_d = {latest_q[WORD_W-2:0], 1'b0};
         data_d = latest_q[WORD_W-1];
         bit_d = '0;
         active_d = 1'b1;
         busy_d = 1'b1;
      end else if (active_q) begin
         data_d = shift_q[WORD_W-1];
         shift_d = {shift_q[WORD_W-2:0], 1'b0};
         bit_d = bit_q + 6'h01;
         if (last_bit) begin
            active_d = 1'b0;
            busy_d = 1'b0;
         end
      end
   end

   always_ff @(posedge link_clk or negedge link_nrst) begin
      if (!link_nrst) begin
         shift_q <= '0;
         bit_q <= '0;
         active_q <= 1'b0;
      end else begin
         shift_q <= shift_d;
         bit_q <= bit_d;
         active_q <= active_d;
      end
   end

   always_ff @(posedge link_clk or negedge link_nrst) begin
      if (!link_nrst) begin
         data_out <= 1'b0;
         busy <= 1'b0;
      end else begin
         data_out <= data_d;
         busy <= busy_d;
      end
   end

endmodule // spt_transmitter

// Three-stage synchroniser; a change counts once stages two and three
// agree, which filters a runt at the cost of one more cycle
module spt_sync3
   import spt_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic d,
   output logic sync_q
);

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic sync_d;
   logic agree;
   assign agree = (s2_q == s3_q);
   assign sync_d = agree ? s3_q : sync_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
      end
   end

endmodule // spt_sync3

// Two-entry buffer with valid and ready on both sides
module spt_buf2
   import spt_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire spt_word_s in_word,
   output logic out_valid,
   input wire logic out_ready,
   output spt_word_s out_word
);

   spt_word_s mem_q [BUF_DEPTH];
   logic wr_ptr_q;
   logic wr_ptr_d;
   logic rd_ptr_q;
   logic rd_ptr_d;
   logic [1:0] count_q;
   logic [1:0] count_d;
   logic full;
   logic push;
   logic pop;
   // Ready is registered for the source, so it looks one word ahead:
   // it drops only when the buffer will be full after this cycle
   assign full = (count_q == 2'h2);
   assign push = in_valid && !full;
   assign out_valid = (count_q != 2'h0);
   assign pop = out_valid && out_ready;
   assign out_word = mem_q[rd_ptr_q];
   assign wr_ptr_d = push ? ~wr_ptr_q : wr_ptr_q;
   assign rd_ptr_d = pop ? ~rd_ptr_q : rd_ptr_q;
   assign count_d = count_q + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q <= count_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_ready <= 1'b0;
      end else begin
         in_ready <= (count_d != 2'h2);
      end
   end

   // Storage has no reset; out_valid guards every read of it
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_word;
      end
   end

endmodule // spt_buf2

/* tb/spt_transmitter_sva.sv */
`timescale 1ns/1ps
module spt_transmitter_chk (
   input wire logic link_clk,
   input wire logic link_nrst,
   input wire logic frame_start,
   input wire logic data_out,
   input wire logic busy
);
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   // Counts link edges of the running frame; a restart reloads it
   assign cnt_d = frame_start ? 6'h01 : (busy ? cnt_q + 6'h01 : 6'h00);
   always_ff @(posedge link_clk or negedge link_nrst)
      if (!link_nrst) cnt_q <= 6'h00;
      else cnt_q <= cnt_d;
   default clocking @(posedge link_clk); endclocking
   default disable iff (!link_nrst);
   property p_start; frame_start |=> busy && cnt_q == 6'h01; endproperty
   a_start: assert property (p_start) else $error("no busy");
   property p_rise; $rose(busy) |-> $past(frame_start); endproperty
   a_rise: assert property (p_rise) else $error("busy rose");
   property p_len; $fell(busy) |-> cnt_q == 6'h20; endproperty
   a_len: assert property (p_len) else $error("frame len");
   property p_cnt; busy |-> cnt_q != 6'h00 && cnt_q < 6'h20; endproperty
   a_cnt: assert property (p_cnt) else $error("bit count");
   property p_idle;
      !$past(busy) && !$past(frame_start) |-> !data_out;
   endproperty
   a_idle: assert property (p_idle) else $error("idle data");
   property p_run; busy && !frame_start && cnt_q < 6'h1f |=> busy; endproperty
   a_run: assert property (p_run) else $error("short frame");
   property p_stay; !busy && !frame_start |=> !busy; endproperty
   a_stay: assert property (p_stay) else $error("busy idle");
endmodule // spt_transmitter_chk
bind spt_transmitter spt_transmitter_chk u_spt_transmitter_chk (
   .link_clk(link_clk), .link_nrst(link_nrst), .frame_start(frame_start),
   .data_out(data_out), .busy(busy));

/* tb/spt_ctrl_model.sv */
`timescale 1ns/1ps
module spt_ctrl_model (
   input wire logic go,
   output logic link_clk,
   output logic frame_start,
   input wire logic data_out,
   output logic [31:0] word
);
   initial begin
      link_clk = 0;
      frame_start = 0;
      word = '0;
   end
   // Clock only runs within a frame, 30 ns period
   always @(posedge go) begin
      frame_start = 1;
      for (int i = 0; i < 32; i++) begin
         #15 link_clk = 1;
         #1 frame_start = 0;
         #14 link_clk = 0;
         word = {word[30:0], data_out};
      end
   end
endmodule // spt_ctrl_model

/* tb/test_spt_transmitter.sv */
`timescale 1ns/1ps
module test_spt_transmitter
   import spt_pkg::*;
;
   logic clk = 0, nrst = 0, link_nrst = 0, src_valid = 0, go = 0;
   logic [SEL_W-1:0] var_sel = '0;
   logic signed [WORD_W-1:0] position = '0, home_offset = '0;
   logic [WORD_W-1:0] alt_value = '0, word;
   logic src_ready, link_clk, frame_start, data_out, busy;
   int failures = 0, checked = 0;
   always #4 clk = ~clk;
   spt_transmitter u_spt_transmitter (.clk(clk), .nrst(nrst),
      .var_sel(var_sel), .position(position), .home_offset(home_offset),
      .alt_value(alt_value), .src_valid(src_valid), .src_ready(src_ready),
      .link_clk(link_clk), .link_nrst(link_nrst),
      .frame_start(frame_start), .data_out(data_out), .busy(busy));
   spt_ctrl_model u_spt_ctrl_model (.go(go), .link_clk(link_clk),
      .frame_start(frame_start), .data_out(data_out), .word(word));
   task automatic tally_and_finish;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [WORD_W-1:0] got, exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic offer(input logic [SEL_W-1:0] s, input logic [31:0] p, h, a);
      @(negedge clk);
      {var_sel, position, home_offset, alt_value, src_valid} = {s, p, h, a, 1'b1};
      repeat (50) if (src_ready !== 1'b1) @(negedge clk);
      if (src_ready !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
      @(negedge clk);
      src_valid = 0;
   endtask
   // A whole frame of 32 link clocks; the first one after an offer syncs
   task automatic pump;
      go = 1'b1;
      #980;
      go = 1'b0;
      #20;
   endtask
   task automatic frame(input logic [WORD_W-1:0] exp);
      pump();
      chk(word, exp);
   endtask
   task automatic sc_pos;
      offer(VAR_POS_ID, 32'h1234_5678, 32'h0000_1111, 32'h0f0f_0f0f);
      pump();
      frame(32'h1234_4567);
      frame(32'h1234_4567);
      offer(VAR_POS_ID, 32'h5, 32'h9, 32'h0f0f_0f0f);
      pump();
      frame(32'hffff_fffc);
   endtask
   task automatic sc_sel;
      offer(16'h0001, 32'h7, 32'h1, 32'ha5c3_0f81);
      pump();
      frame(32'ha5c3_0f81);
   endtask
   task automatic sc_full;
      @(negedge clk);
      src_valid = 1;
      repeat (6) @(negedge clk);
      chk({31'h0, src_ready}, 32'h0);
      src_valid = 0;
      pump();
      frame(32'ha5c3_0f81);
      chk({31'h0, src_ready}, 32'h1);
   endtask
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1;
      pump();
      link_nrst = 1;
      sc_pos();
      sc_sel();
      sc_full();
      tally_and_finish();
   end
endmodule // test_spt_transmitter
